// ---- rtl/egp_gear_phasing.sv ----
// Electronic gear slave with four phasing profiles, AHB-Lite registers.
// Assumes master speed and position come from logic on the same clock.
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
module egp_gear_phasing (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [egp_pkg::DW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [egp_pkg::DW-1:0] hwdata,
  input wire logic hready,
  output logic [egp_pkg::DW-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [egp_pkg::DW-1:0] master_speed,
  input wire logic [egp_pkg::DW-1:0] master_pos,
  output logic [egp_pkg::DW-1:0] slave_speed,
  output logic [egp_pkg::DW-1:0] slave_pos,
  output logic phasing_done,
  output logic gear_active,
  output logic irq
);
  import egp_pkg::*;

  typedef struct packed {
    logic ap_act;
    logic ap_wr;
    logic [AW-1:0] ap_addr;
    logic [31:0] rdata;
    logic [15:0] num;
    logic [15:0] den;
    logic [15:0] resync;
    logic [3:0][31:0] off;
    logic [3:0][31:0] spd;
    logic [3:0][31:0] acc;
    logic [15:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] opm;
    logic [31:0] pacc;
    logic start_q;
    logic [1:0] sel;
    egp_ph_e st;
    logic [31:0] shift;
    logic [31:0] tgt;
    logic [31:0] vel;
    logic neg;
    logic done;
    logic busy;
    logic arm;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic [31:0] spd_out;
    logic [31:0] pos_out;
  } egp_main_s;

  egp_main_s s_q;
  egp_main_s s_d;

  egp_ramp_if gear_ramp ();
  egp_ratio_if gear_ratio ();

  logic active;
  logic map_ok;
  logic start_edge;
  logic [AW-1:0] ph_rel;
  logic [AW-1:0] wr_rel;
  logic [31:0] rv;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic signed [32:0] rem;
  logic [32:0] mag;
  logic [32:0] vsum;
  logic [31:0] vnext;
  logic [31:0] pvel;

  function automatic logic [31:0] clamp_off(input logic [31:0] v);
    clamp_off = (v == OFF_BAD) ? OFF_MIN : v;
  endfunction

  function automatic logic [31:0] clamp_lim(input logic [31:0] v);
    if (v == 32'h0) begin
      clamp_lim = LIM_MIN;
    end else if (v[31]) begin
      clamp_lim = LIM_MAX;
    end else begin
      clamp_lim = v;
    end
  endfunction

  egp_ratio u_ratio (
    .clk(clk),
    .rst(rst),
    .rif(gear_ratio)
  );

  egp_ramp u_ramp (
    .clk(clk),
    .rst(rst),
    .rif(gear_ramp)
  );

  assign gear_ratio.master = master_speed;
  assign gear_ratio.num = s_q.num;
  assign gear_ratio.den = s_q.den;

  assign gear_ramp.target = active ? gear_ratio.scaled : master_speed;
  assign gear_ramp.step = s_q.pacc;
  assign gear_ramp.bypass = ~s_q.busy;

  always_comb begin
    s_d = s_q;
    ev = '0;
    clr = '0;
    rv = '0;
    rem = '0;
    mag = '0;
    vsum = '0;
    vnext = '0;
    active = (s_q.cfg == CFG_MC) && (s_q.opm == OPM_GEAR);
    start_edge = s_q.ctrl[CW_START] & ~s_q.start_q;
    s_d.start_q = s_q.ctrl[CW_START];
    map_ok = (haddr[DW-1:AW] == '0);
    ph_rel = haddr[AW-1:0] - A_PH_BASE;
    wr_rel = s_q.ap_addr - A_PH_BASE;

    // Address phase and read data
    s_d.ap_act = hsel & hready & htrans[1];
    s_d.ap_wr = hwrite;
    s_d.ap_addr = haddr[AW-1:0];
    if (!map_ok) begin
      rv = '0;
    end else if (haddr[AW-1:0] >= A_PH_BASE && haddr[AW-1:0] < A_CTRL) begin
      case (ph_rel[3:2])
        PH_OFF: rv = s_q.off[ph_rel[5:4]];
        PH_SPD: rv = s_q.spd[ph_rel[5:4]];
        PH_ACC: rv = s_q.acc[ph_rel[5:4]];
        default: rv = {24'h0, SUBIDX_MAX};
      endcase
    end else begin
      case (haddr[AW-1:0])
        A_GEAR_SUB: rv = {24'h0, SUBIDX_MAX};
        A_NUM: rv = {{16{s_q.num[15]}}, s_q.num};
        A_DEN: rv = {16'h0, s_q.den};
        A_RESYNC: rv = {16'h0, s_q.resync};
        A_CTRL: rv = {16'h0, s_q.ctrl};
        A_MODE: rv = {16'h0, s_q.cfg, s_q.opm};
        A_STATUS: rv[SW_DONE] = s_q.done;
        A_PACC: rv = s_q.pacc;
        A_IRQ_ST: rv = {30'h0, s_q.ist};
        A_IRQ_MASK: rv = {30'h0, s_q.imask};
        A_SPEED: rv = s_q.spd_out;
        A_SHIFT: rv = s_q.shift;
        default: rv = '0;
      endcase
    end
    s_d.rdata = (hsel & hready & htrans[1] & ~hwrite) ? rv : s_q.rdata;

    // Data phase write to working copies
    if (s_q.ap_act && s_q.ap_wr) begin
      if (s_q.ap_addr >= A_PH_BASE && s_q.ap_addr < A_CTRL) begin
        case (wr_rel[3:2])
          PH_OFF: s_d.off[wr_rel[5:4]] = clamp_off(hwdata);
          PH_SPD: s_d.spd[wr_rel[5:4]] = clamp_lim(hwdata);
          PH_ACC: s_d.acc[wr_rel[5:4]] = clamp_lim(hwdata);
          default: s_d.off = s_q.off;
        endcase
      end else begin
        case (s_q.ap_addr)
          A_NUM: s_d.num = hwdata[15:0];
          A_DEN: s_d.den = hwdata[15:0];
          A_RESYNC: s_d.resync = hwdata[15:0];
          A_CTRL: s_d.ctrl = hwdata[15:0];
          A_MODE: begin
            s_d.opm = hwdata[MODE_OPM_LO +: 8];
            s_d.cfg = hwdata[MODE_CFG_LO +: 8];
          end
          A_PACC: s_d.pacc = clamp_lim(hwdata);
          A_IRQ_ST: clr = hwdata[IRQ_W-1:0];
          A_IRQ_MASK: s_d.imask = hwdata[IRQ_W-1:0];
          default: s_d.ctrl = s_q.ctrl;
        endcase
      end
    end

    if ((s_d.num != s_q.num || s_d.den != s_q.den) && s_q.resync == RESYNC_ON
        && active) begin
      s_d.busy = 1'b1;
      s_d.arm = 1'b1;
    end else if (s_q.arm) begin
      s_d.arm = 1'b0;
    end else if (s_q.busy && (gear_ramp.settled || !active
        || s_q.resync != RESYNC_ON)) begin
      // Resync ends on settle or off
      s_d.busy = 1'b0;
      ev[IRQ_RESYNC] = 1'b1;
    end

    // Phasing sequence
    case (s_q.st)
      EGP_IDLE: begin
        if (active && start_edge) begin
          s_d.st = EGP_RUN;
          s_d.sel = s_q.ctrl[CW_SEL_LO +: 2];
          s_d.tgt = s_q.off[s_q.ctrl[CW_SEL_LO +: 2]];
          s_d.vel = '0;
          s_d.done = 1'b0;
        end
      end
      EGP_RUN: begin
        if (!active || !s_q.ctrl[CW_START]) begin
          s_d.st = EGP_IDLE;
          s_d.vel = '0;
          s_d.done = 1'b1;
          ev[IRQ_DONE] = 1'b1;
        end else begin
          rem = 33'($signed(s_q.tgt)) - 33'($signed(s_q.shift));
          mag = rem[32] ? 33'(-rem) : 33'(rem);
          vsum = {1'b0, s_q.vel} + {1'b0, s_q.acc[s_q.sel]};
          vnext = (vsum > {1'b0, s_q.spd[s_q.sel]}) ? s_q.spd[s_q.sel] : vsum[31:0];
          if (mag <= {1'b0, vnext}) begin
            s_d.shift = s_q.tgt;
            s_d.vel = '0;
            s_d.st = EGP_IDLE;
            s_d.done = 1'b1;
            ev[IRQ_DONE] = 1'b1;
          end else begin
            s_d.shift = rem[32] ? s_q.shift - vnext : s_q.shift + vnext;
            s_d.vel = vnext;
            s_d.neg = rem[32];
          end
        end
      end
      default: s_d.st = EGP_IDLE;
    endcase

    // Sticky status, set wins over clear
    s_d.ist = (s_q.ist & ~clr) | ev;

    pvel = s_q.neg ? 32'(-s_q.vel) : s_q.vel;
    if (active) begin
      s_d.spd_out = gear_ramp.value + ((s_q.st == EGP_RUN) ? pvel : 32'h0);
      s_d.pos_out = master_pos + s_q.shift;
    end else begin
      s_d.spd_out = master_speed;
      s_d.pos_out = master_pos;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.num <= NUM_RST;
      s_q.den <= DEN_RST;
      s_q.resync <= RESYNC_RST;
      s_q.off <= {4{PH_OFF_RST}};
      s_q.spd <= {4{PH_SPD_RST}};
      s_q.acc <= {4{PH_ACC_RST}};
      s_q.pacc <= PACC_RST;
      s_q.st <= EGP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign slave_speed = s_q.spd_out;
  assign slave_pos = s_q.pos_out;
  assign phasing_done = s_q.done;
  assign gear_active = active;
  assign irq = |(s_q.ist & s_q.imask);
endmodule

// ---- rtl/egp_pkg.sv ----
// Constants and types for the electronic gear and phasing block.
// Assumes a single 10 MHz clock and an AHB-Lite register port.
package egp_pkg;
  localparam int DW = 32;
  localparam int AW = 7;
  // Register byte addresses
  localparam logic [6:0] A_GEAR_SUB = 7'h00;
  localparam logic [6:0] A_NUM = 7'h04;
  localparam logic [6:0] A_DEN = 7'h08;
  localparam logic [6:0] A_RESYNC = 7'h0c;
  localparam logic [6:0] A_PH_BASE = 7'h20;
  localparam logic [6:0] A_CTRL = 7'h60;
  localparam logic [6:0] A_MODE = 7'h64;
  localparam logic [6:0] A_STATUS = 7'h68;
  localparam logic [6:0] A_PACC = 7'h6c;
  localparam logic [6:0] A_IRQ_ST = 7'h70;
  localparam logic [6:0] A_IRQ_MASK = 7'h74;
  localparam logic [6:0] A_SPEED = 7'h78;
  localparam logic [6:0] A_SHIFT = 7'h7c;
  // Sub-entries inside one phasing profile block
  localparam logic [1:0] PH_OFF = 2'h0;
  localparam logic [1:0] PH_SPD = 2'h1;
  localparam logic [1:0] PH_ACC = 2'h2;
  localparam logic [1:0] PH_SUB = 2'h3;
  // Reset values, the read-only subindex count and the resync-on value
  localparam logic [7:0] SUBIDX_MAX = 8'h03;
  localparam logic [15:0] NUM_RST = 16'h0001;
  localparam logic [15:0] DEN_RST = 16'h0001;
  localparam logic [15:0] RESYNC_RST = 16'h0001;
  localparam logic [15:0] RESYNC_ON = 16'h0001;
  localparam logic [31:0] PH_OFF_RST = 32'h0001_0000;
  localparam logic [31:0] PH_SPD_RST = 32'h0005_0000;
  localparam logic [31:0] PH_ACC_RST = 32'h0005_0000;
  localparam logic [31:0] PACC_RST = 32'h0000_0100;
  // Value limits
  localparam logic [31:0] OFF_MIN = 32'h8000_0001;
  localparam logic [31:0] OFF_BAD = 32'h8000_0000;
  localparam logic [31:0] LIM_MIN = 32'h0000_0001;
  localparam logic [31:0] LIM_MAX = 32'h7fff_ffff;
  // Control, status and mode fields
  localparam int CW_START = 9;
  localparam int CW_SEL_LO = 12;
  localparam int SW_DONE = 8;
  localparam int MODE_OPM_LO = 0;
  localparam int MODE_CFG_LO = 8;
  localparam logic [7:0] CFG_MC = 8'h40;
  localparam logic [7:0] OPM_GEAR = 8'hfd;
  // Interrupt bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RESYNC = 1;
  typedef enum logic [1:0] {EGP_IDLE, EGP_RUN} egp_ph_e;
endpackage

// ---- rtl/egp_if.sv ----
// Interfaces between the gear top and its ratio and ramp helpers.
// Assumes all parties run on the same clock.
interface egp_ramp_if;
  logic [31:0] target;
  logic [31:0] step;
  logic bypass;
  logic [31:0] value;
  logic settled;
  modport ctl (output target, step, bypass, input value, settled);
  modport ramp (input target, step, bypass, output value, settled);
endinterface

interface egp_ratio_if;
  logic [31:0] master;
  logic [15:0] num;
  logic [15:0] den;
  logic [31:0] scaled;
  modport ctl (output master, num, den, input scaled);
  modport calc (input master, num, den, output scaled);
endinterface

// ---- rtl/egp_ratio.sv ----
// Scales master speed by signed numerator over unsigned denominator.
// Assumes the same clock as the top; result is one cycle late.
module egp_ratio (
  input wire logic clk,
  input wire logic rst,
  egp_ratio_if.calc rif
);
  import egp_pkg::*;
  typedef struct packed {
    logic [31:0] scaled;
  } egp_ratio_s;
  egp_ratio_s s_q;
  egp_ratio_s s_d;
  logic signed [47:0] prod;
  logic signed [47:0] quo;
  always_comb begin
    s_d = s_q;
    prod = 48'($signed(rif.master)) * 48'($signed(rif.num));
    quo = prod / $signed({32'h0, rif.den});
    if (rif.den != 16'h0) begin
      s_d.scaled = quo[31:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rif.scaled = s_q.scaled;
endmodule

// ---- rtl/egp_ramp.sv ----
// Moves its value toward a target by at most one step per clock, or straight to it on bypass.
// Assumes the step is at least one when ramping is in use.
module egp_ramp (
  input wire logic clk,
  input wire logic rst,
  egp_ramp_if.ramp rif
);
  import egp_pkg::*;
  typedef struct packed {
    logic [31:0] value;
  } egp_ramp_s;
  egp_ramp_s s_q;
  egp_ramp_s s_d;
  logic signed [32:0] diff;
  logic [32:0] mag;
  always_comb begin
    s_d = s_q;
    diff = 33'($signed(rif.target)) - 33'($signed(s_q.value));
    mag = diff[32] ? 33'(-diff) : 33'(diff);
    if (rif.bypass || mag <= {1'b0, rif.step}) begin
      s_d.value = rif.target;
    end else if (diff[32]) begin
      s_d.value = s_q.value - rif.step;
    end else begin
      s_d.value = s_q.value + rif.step;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rif.value = s_q.value;
  assign rif.settled = (s_q.value == rif.target);
endmodule

// ---- dv/egp_master_src.sv ----
// Master axis source standing in for the drive's master side.
// Assumes the bench sets the speed; position integrates it each clock.
module egp_master_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic [egp_pkg::DW-1:0] speed,
  output logic [egp_pkg::DW-1:0] master_speed,
  output logic [egp_pkg::DW-1:0] master_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      master_speed <= '0;
      master_pos <= 32'h0000_1000;
    end else begin
      master_speed <= speed;
      master_pos <= master_pos + speed;
    end
  end
endmodule

// ---- dv/egp_props.sv ----
// Port-level checks for the gear and phasing block.
// Assumes one clock and the AHB slave as the only bus slave.
module egp_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [egp_pkg::DW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [egp_pkg::DW-1:0] hwdata,
  input wire logic hready,
  input wire logic [egp_pkg::DW-1:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [egp_pkg::DW-1:0] master_speed,
  input wire logic [egp_pkg::DW-1:0] master_pos,
  input wire logic [egp_pkg::DW-1:0] slave_speed,
  input wire logic [egp_pkg::DW-1:0] slave_pos,
  input wire logic phasing_done,
  input wire logic gear_active,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import egp_pkg::*;
  logic seen_q;
  logic [DW-1:0] mpos_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
      mpos_q <= '0;
    end else begin
      seen_q <= seen_q | gear_active;
      mpos_q <= master_pos;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  ready_high_a: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  read_hold_a: assert property (!$past(hsel && htrans[1] && !hwrite) && !$past(rst)
    |-> $stable(hrdata)) else $error("hrdata changed without read");
  follow_speed_a: assert property (!gear_active && !$past(gear_active) && !$past(rst)
    |-> slave_speed == $past(master_speed)) else $error("slave speed not following");
  follow_pos_a: assert property (!gear_active && !$past(gear_active) && !$past(rst)
    |-> slave_pos == $past(master_pos)) else $error("slave pos not following");
  done_gate_a: assert property (!seen_q |-> !phasing_done)
    else $error("done high before any gear run");
  irq_gate_a: assert property (!seen_q |-> !irq)
    else $error("irq before any gear run");
  done_fall_a: assert property ($fell(phasing_done) |-> gear_active)
    else $error("phasing began outside gear mode");
  shift_hold_a: assert property (gear_active && $past(gear_active) && $past(gear_active, 2)
    && phasing_done && $past(phasing_done) && $past(phasing_done, 2)
    |-> $stable(slave_pos - mpos_q)) else $error("shift moved while done");
  cover property ($fell(phasing_done));
  cover property ($rose(phasing_done));
  cover property ($rose(irq));
endmodule
bind egp_gear_phasing egp_props u_props (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .master_speed(master_speed),
  .master_pos(master_pos), .slave_speed(slave_speed), .slave_pos(slave_pos),
  .phasing_done(phasing_done), .gear_active(gear_active), .irq(irq));

// ---- dv/tb.sv ----
// Register-level bench for the gear and phasing block.
// Assumes zero-wait AHB-Lite slave and a master source model.
module tb import egp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, phasing_done, gear_active, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, speed, master_speed, master_pos, slave_speed, slave_pos, rd;
  int mismatches, n_tests, steps;
  logic [31:0] ra [12] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h20, 32'h24, 32'h28, 32'h2c,
    32'h50, 32'h5c, 32'h68, 32'h80};
  logic [31:0] re [12] = '{32'h3, 32'h1, 32'h1, 32'h1, 32'h1_0000, 32'h5_0000, 32'h5_0000,
    32'h3, 32'h1_0000, 32'h3, 32'h0, 32'h0};
  assign hready = hreadyout;
  egp_master_src src (.clk(clk), .rst(rst), .speed(speed), .master_speed(master_speed),
    .master_pos(master_pos));
  egp_gear_phasing dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .master_speed(master_speed),
    .master_pos(master_pos), .slave_speed(slave_speed), .slave_pos(slave_pos),
    .phasing_done(phasing_done), .gear_active(gear_active), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic bound_fail(input string what);
    mismatches++;
    $display("Error %s expected answer seen timeout", what);
    report_and_stop();
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1) bound_fail("hready");
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0);
    chk_word(what, exp, rd);
  endtask
  task automatic wait_done(input logic v);
    int i;
    i = 0;
    while (phasing_done !== v && i < 300) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (phasing_done !== v) bound_fail("phasing_done");
  endtask
  task automatic ramp_to(input logic [31:0] v, input int lim);
    int i;
    int dlt;
    logic [31:0] prev;
    i = 0;
    steps = 0;
    while (slave_speed !== v && i < 100) begin
      prev = slave_speed;
      @(posedge clk);
      #1;
      dlt = int'($signed(slave_speed - prev));
      if (dlt != 0) steps++;
      chk_flag("speed step limit", 1'b1, dlt <= lim && dlt >= -lim);
      i++;
    end
    if (slave_speed !== v) bound_fail("slave_speed");
  endtask
  initial begin
    #(100 * 60000);
    bound_fail("run");
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    speed = 32'd100;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) rd_chk(ra[i], re[i], "reset value");
    chk_flag("done after reset", 1'b0, phasing_done);
    wr(A_GEAR_SUB, 32'hff);
    rd_chk(A_GEAR_SUB, 32'h3, "ro subindex");
    wr(A_NUM, 32'h3);
    chk_word("follow speed", 32'd100, slave_speed);
    chk_flag("gear off", 1'b0, gear_active);
    wr(A_RESYNC, 32'h0);
    wr(A_DEN, 32'h2);
    wr(A_MODE, 32'h40fd);
    chk_flag("gear on", 1'b1, gear_active);
    ramp_to(32'd150, 200);
    wr(A_NUM, 32'hffff_fffe);
    ramp_to(-32'sd100, 400);
    rd_chk(A_NUM, 32'hffff_fffe, "signed numerator");
    chk_word("step count", 32'd1, steps);
    wr(A_PACC, 32'd10);
    wr(A_IRQ_MASK, 32'h2);
    wr(A_RESYNC, 32'h1);
    wr(A_NUM, 32'h1);
    ramp_to(32'd50, 10);
    chk_word("ramp steps", 32'd15, steps);
    chk_flag("resync irq", 1'b1, irq);
    wr(A_IRQ_ST, 32'h2);
    chk_flag("resync irq clear", 1'b0, irq);
    wr(A_IRQ_MASK, 32'h0);
    wr(A_PH_BASE, 32'h8000_0000);
    rd_chk(A_PH_BASE, 32'h8000_0001, "offset clamp");
    wr(A_PH_BASE + 7'h04, 32'h0);
    rd_chk(A_PH_BASE + 7'h04, 32'h1, "speed clamp");
    wr(A_PH_BASE + 7'h08, 32'hffff_ffff);
    rd_chk(A_PH_BASE + 7'h08, 32'h7fff_ffff, "accel clamp");
    speed <= 32'd0;
    for (int p = 0; p < 4; p++) begin
      wr(A_PH_BASE + 7'(16 * p), 32'(100 * (p + 1)));
      wr(A_PH_BASE + 7'(16 * p + 4), 32'd10);
      wr(A_PH_BASE + 7'(16 * p + 8), 32'd2);
    end
    for (int p = 0; p < 4; p++) begin
      wr(A_CTRL, 32'(p << 12) | 32'h200);
      wait_done(1'b0);
      wr(A_CTRL, 32'((3 - p) << 12) | 32'h200);
      wait_done(1'b1);
      rd_chk(A_SHIFT, 32'(100 * (p + 1)), "phase shift");
      chk_word("slave pos", master_pos + 32'(100 * (p + 1)), slave_pos);
      rd_chk(A_STATUS, 32'h100, "status done");
      chk_flag("phase irq", p != 0, irq);
      wr(A_IRQ_ST, 32'h1);
      chk_flag("phase irq clear", 1'b0, irq);
      if (p == 0) wr(A_IRQ_MASK, 32'h1);
      wr(A_CTRL, 32'h0);
    end
    wr(A_PH_BASE, 32'h0010_0000);
    wr(A_CTRL, 32'h200);
    wait_done(1'b0);
    wr(A_CTRL, 32'h0);
    wait_done(1'b1);
    bus(A_SHIFT, 1'b0, 32'h0);
    chk_flag("cancel keeps shift", 1'b1, rd !== 32'h0010_0000);
    wr(A_MODE, 32'h0);
    chk_flag("gear left", 1'b0, gear_active);
    report_and_stop();
  end
endmodule
